// *** inc/irq_timer_pkg.sv ***
/*
  Shared constants, field layouts, command codes and carrier types of the
  global interrupt status and general purpose timer block.
  Assumes a register port with byte offsets and 32-bit data words.
*/
package irq_timer_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets.
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] TIMER_OFS  = 8'h84;

  // Status word field positions.
  localparam int REQ_LSB   = 0;
  localparam int CODE0_LSB = 8;
  localparam int CODE1_LSB = 11;
  localparam int CODE_W    = 3;

  // Timer word field positions.
  localparam int CMD_LSB    = 0;
  localparam int CMD_W      = 4;
  localparam int RDB_LSB    = 0;
  localparam int LIM_LO_LSB = 16;
  localparam int LIM_HI_LSB = 24;
  localparam int LIM_W      = 16;

  // Reset and fixed values.
  localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [LIM_W-1:0]  LIMIT_RST  = 16'h0000;
  localparam logic [LIM_W-1:0]  LIMIT_MIN  = 16'h0002;
  localparam logic [7:0]        TMR_RD_PEND = 8'h01;
  localparam logic [7:0]        TMR_RD_NONE = 8'h00;
  localparam int                SYNC_STAGES = 2;

  // Interrupt source codes, lower value wins.
  localparam logic [CODE_W-1:0] CODE_NONE  = 3'h0;
  localparam logic [CODE_W-1:0] CODE_RX    = 3'h1;
  localparam logic [CODE_W-1:0] CODE_RXTO  = 3'h2;
  localparam logic [CODE_W-1:0] CODE_TX    = 3'h3;
  localparam logic [CODE_W-1:0] CODE_MODEM = 3'h4;
  localparam logic [CODE_W-1:0] CODE_PIN   = 3'h6;
  localparam logic [CODE_W-1:0] CODE_TMR   = 3'h7;

  // Timer command codes.
  localparam logic [CMD_W-1:0] CMD_NOP      = 4'h0;
  localparam logic [CMD_W-1:0] CMD_INT_EN   = 4'h1;
  localparam logic [CMD_W-1:0] CMD_INT_DIS  = 4'h2;
  localparam logic [CMD_W-1:0] CMD_ONESHOT  = 4'h3;
  localparam logic [CMD_W-1:0] CMD_RETRIG   = 4'h4;
  localparam logic [CMD_W-1:0] CMD_CLK_INT  = 4'h5;
  localparam logic [CMD_W-1:0] CMD_CLK_EXT  = 4'h6;
  localparam logic [CMD_W-1:0] CMD_ROUTE    = 4'h7;
  localparam logic [CMD_W-1:0] CMD_DEROUTE  = 4'h8;
  localparam logic [CMD_W-1:0] CMD_START    = 4'h9;
  localparam logic [CMD_W-1:0] CMD_STOP     = 4'ha;
  localparam logic [CMD_W-1:0] CMD_RESET    = 4'hb;

  // Timer states.
  typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_DONE} tmr_state_e;

  // Event pulses from one serial channel.
  typedef struct packed {
    logic rx_ready;
    logic rx_line_err;
    logic rx_timeout;
    logic tx_ready;
    logic modem_evt;
    logic flow_evt;
  } chan_evt_s;

  // Register read strobes from one serial channel.
  typedef struct packed {
    logic rx_fifo_rd;
    logic lsr_rd;
    logic isr_rd;
    logic msr_rd;
  } chan_rd_s;

endpackage

// *** hdl/level_sync.sv ***
/*
  Two flip-flop synchroniser for one level from outside the clock domain.
  Assumes the level changes slower than half the clock rate.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync
  import irq_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Level in and out.
  input  wire logic async_i,
  output logic      sync_o
);

  logic [SYNC_STAGES-1:0] stage_ff;

  // The first stage is read only by the second stage.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage_ff <= '0;
    end else begin
      stage_ff <= {stage_ff[SYNC_STAGES-2:0], async_i};
    end
  end

  assign sync_o = stage_ff[SYNC_STAGES-1];

endmodule
`default_nettype wire

// *** hdl/chan_src_flags.sv ***
/*
  Sticky interrupt sources of one serial channel and their priority code.
  Assumes event pulses and read strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module chan_src_flags
  import irq_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Channel events and register reads.
  input  wire irq_timer_pkg::chan_evt_s evt_i,
  input  wire irq_timer_pkg::chan_rd_s  rd_i,
  // Request and code.
  output logic                       req_o,
  output logic [CODE_W-1:0]          code_o
);

  chan_evt_s flag_ff;
  chan_evt_s nxt_flag;

  // A new event beats a clear in the same cycle.
  assign nxt_flag.rx_ready = evt_i.rx_ready | (flag_ff.rx_ready & ~rd_i.rx_fifo_rd); // [R10]
  assign nxt_flag.rx_timeout = evt_i.rx_timeout | (flag_ff.rx_timeout & ~rd_i.rx_fifo_rd); // [R10]
  assign nxt_flag.rx_line_err = evt_i.rx_line_err | (flag_ff.rx_line_err & ~rd_i.lsr_rd); // [R11]
  assign nxt_flag.tx_ready = evt_i.tx_ready | (flag_ff.tx_ready & ~rd_i.isr_rd); // [R12]
  assign nxt_flag.flow_evt = evt_i.flow_evt | (flag_ff.flow_evt & ~rd_i.isr_rd); // [R12]
  assign nxt_flag.modem_evt = evt_i.modem_evt | (flag_ff.modem_evt & ~rd_i.msr_rd); // [R13]

  // Source flags.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  // Highest priority pending source sets the code.
  assign code_o = (flag_ff.rx_ready | flag_ff.rx_line_err) ? CODE_RX :   // [R6] [R25]
                  flag_ff.rx_timeout                        ? CODE_RXTO :
                  flag_ff.tx_ready                          ? CODE_TX :
                  (flag_ff.modem_evt | flag_ff.flow_evt)    ? CODE_MODEM :
                                                              CODE_NONE; // [R5]
  assign req_o  = |flag_ff; // [R2]

endmodule
`default_nettype wire

// *** hdl/global_interrupt_and_timer_status.sv ***
/*
  Global interrupt status word for a two channel serial bridge, with the
  general purpose 16-bit timer whose timeout feeds channel 0's code.
  Assumes per channel event pulses and register read strobes from the
  channel logic on sys_clk_i, and an external count clock from a pin.
  The internal timer clock is sys_clk_i itself.
*/
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: bits 0 and 1 flag channel service requests.
// R2: request set while channel needs service.
// R3: codes sit at bits 10:8 and 13:11.
// R4: requests and codes share one word.
// R5: code zero means none or wake-up.
// R6: codes 1 to 4 by priority.
// R7: code 5 unused; 6 pin, 7 timer.
// R8: global interrupts appear only in channel 0.
// R9: wake-up interrupt cleared by status read.
// R10: receive flags clear on receive data read.
// R11: line error clears on line status read.
// R12: transmit and flow flags clear on identification read.
// R13: modem flags clear on modem status read.
// R14: timer interrupt clears on command register read.
// R15: pin interrupt clears on pin level read.
// R16: status word is zero after reset.
// R17: timer counts internal or external clock.
// R18: one-shot and re-triggerable timer modes.
// R19: timer output optionally drives pin 0.
// R20: limit is high byte over low byte.
// R21: limit reads back programmed value, not count.
// R22: limit resets to zero; timer reset keeps it.
// R23: command read gives 01 when enabled and pending.
// R24: interrupt at timeout or every N ticks.
// R25: lowest priority number wins within a channel.
module global_interrupt_and_timer_status #(
  parameter int CH_N = 2
) (
  // Clock and reset.
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // Register port.
  input  wire logic [irq_timer_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [irq_timer_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic [irq_timer_pkg::DATA_W-1:0] rdata_o,
  // Serial channel events and read strobes.
  input  wire irq_timer_pkg::chan_evt_s [CH_N-1:0] chan_evt_i,
  input  wire irq_timer_pkg::chan_rd_s  [CH_N-1:0] chan_rd_i,
  // Device-wide event sources.
  input  wire logic                        wake_evt_i,
  input  wire logic                        pin_irq_evt_i,
  input  wire logic                        pin_level_rd_i,
  // External timer clock pin.
  input  wire logic                        external_count_clock_i,
  // Multipurpose pin 0 drive.
  output logic                             mpin0_o,
  output logic                             mpin0_oe_o
);
  import irq_timer_pkg::*;

  // The field layout of the status word only has room for two channels.
  if (CH_N != 2) begin : g_bad_ch
    $error("CH_N must be 2");
  end

  // Register bus decode.
  wire hit_stat = (addr_i == STATUS_OFS);
  wire hit_tmr  = (addr_i == TIMER_OFS);
  wire stat_rd  = rd_i & hit_stat;
  wire tmr_rd   = rd_i & hit_tmr;
  wire tmr_wr   = wr_i & hit_tmr;
  wire [CMD_W-1:0] cmd = wdata_i[CMD_LSB +: CMD_W];

  // Per channel source flags.
  logic [CH_N-1:0]   req;
  logic [CODE_W-1:0] code [CH_N];

  for (genvar ch = 0; ch < CH_N; ch++) begin : g_chan
    chan_src_flags u_flags (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .evt_i     (chan_evt_i[ch]),
      .rd_i      (chan_rd_i[ch]),
      .req_o     (req[ch]),
      .code_o    (code[ch])
    );
  end

  // External count clock enters through a synchroniser.
  logic ext_sync;

  level_sync u_ext_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (external_count_clock_i),
    .sync_o    (ext_sync)
  );

  // Registers.
  tmr_state_e        tmr_st_ff;
  tmr_state_e        nxt_tmr_st;
  logic [LIM_W-1:0]  cnt_ff;
  logic [LIM_W-1:0]  nxt_cnt;
  logic [LIM_W-1:0]  limit_ff;
  logic [LIM_W-1:0]  nxt_limit;
  logic              out_ff;
  logic              nxt_out;
  logic              int_en_ff;
  logic              nxt_int_en;
  logic              oneshot_ff;
  logic              nxt_oneshot;
  logic              ext_sel_ff;
  logic              nxt_ext_sel;
  logic              route_ff;
  logic              nxt_route;
  logic              tmr_pend_ff;
  logic              ext_prev_ff;
  logic              wake_ff;
  logic              pin_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              tmr_evt;
  logic              tmr_rst_cmd;

  // Counting tick from the selected clock source.
  wire ext_rise = ext_sync & ~ext_prev_ff;
  wire tick     = ext_sel_ff ? ext_rise : 1'b1; // [R17]

  // Phase lengths: high for the lower half, low for the rest.
  wire [LIM_W-1:0] half_p  = limit_ff >> 1;
  wire [LIM_W-1:0] half_q  = limit_ff - half_p;
  wire [LIM_W-1:0] last_n  = limit_ff - 16'h0001;
  wire [LIM_W-1:0] last_p  = half_p - 16'h0001;
  wire [LIM_W-1:0] last_q  = half_q - 16'h0001;
  wire [LIM_W-1:0] cnt_inc = cnt_ff + 16'h0001;
  wire tmr_idle  = (tmr_st_ff == TMR_IDLE);
  wire limit_ok  = (limit_ff >= LIMIT_MIN);

  // Timer counting, then commands from the register port.
  always_comb begin
    nxt_tmr_st  = tmr_st_ff;
    nxt_cnt     = cnt_ff;
    nxt_limit   = limit_ff;
    nxt_out     = out_ff;
    nxt_int_en  = int_en_ff;
    nxt_oneshot = oneshot_ff;
    nxt_ext_sel = ext_sel_ff;
    nxt_route   = route_ff;
    tmr_evt     = 1'b0;
    tmr_rst_cmd = 1'b0;
    unique case (tmr_st_ff)
      TMR_IDLE: begin
        nxt_cnt = '0;
      end
      TMR_RUN: begin
        if (tick) begin
          if (oneshot_ff) begin
            // One-shot times out once after N ticks.
            if (cnt_ff == last_n) begin // [R18] [R24]
              nxt_tmr_st = TMR_DONE;
              nxt_out    = 1'b0;
              nxt_cnt    = '0;
              tmr_evt    = 1'b1;
            end else begin
              nxt_cnt = cnt_inc;
            end
          end else if (out_ff) begin
            // Re-triggerable high phase lasts P ticks.
            if (cnt_ff == last_p) begin // [R18]
              nxt_out = 1'b0;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_inc;
            end
          end else begin
            // Low phase lasts Q ticks; the rising edge interrupts.
            if (cnt_ff == last_q) begin // [R24]
              nxt_out = 1'b1;
              nxt_cnt = '0;
              tmr_evt = 1'b1;
            end else begin
              nxt_cnt = cnt_inc;
            end
          end
        end
      end
      TMR_DONE: begin
        nxt_out = 1'b0;
      end
    endcase
    if (tmr_wr) begin
      // Set-up writes only take effect in TMR_IDLE, not while running or in TMR_DONE.
      case (cmd)
        CMD_NOP: begin
          if (tmr_idle) begin
            nxt_limit = {wdata_i[LIM_HI_LSB +: 8], wdata_i[LIM_LO_LSB +: 8]}; // [R20]
          end
        end
        CMD_INT_EN: begin
          if (tmr_idle) begin
            nxt_int_en = 1'b1;
          end
        end
        CMD_INT_DIS: begin
          if (tmr_idle) begin
            nxt_int_en = 1'b0;
          end
        end
        CMD_ONESHOT: begin
          if (tmr_idle) begin
            nxt_oneshot = 1'b1; // [R18]
          end
        end
        CMD_RETRIG: begin
          if (tmr_idle) begin
            nxt_oneshot = 1'b0;
          end
        end
        CMD_CLK_INT: begin
          if (tmr_idle) begin
            nxt_ext_sel = 1'b0; // [R17]
          end
        end
        CMD_CLK_EXT: begin
          if (tmr_idle) begin
            nxt_ext_sel = 1'b1; // [R17]
          end
        end
        CMD_ROUTE: begin
          if (tmr_idle) begin
            nxt_route = 1'b1; // [R19]
          end
        end
        CMD_DEROUTE: begin
          if (tmr_idle) begin
            nxt_route = 1'b0; // [R19]
          end
        end
        CMD_START: begin
          // A zero or one limit leaves the timer disabled.
          if (tmr_idle && limit_ok) begin
            nxt_tmr_st = TMR_RUN;
            nxt_cnt    = '0;
            nxt_out    = 1'b1;
          end else if (tmr_st_ff == TMR_RUN && oneshot_ff) begin
            nxt_cnt = '0;
          end
        end
        CMD_STOP: begin
          nxt_tmr_st = TMR_IDLE;
          nxt_cnt    = '0;
          nxt_out    = 1'b1;
        end
        CMD_RESET: begin
          // Back to defaults; the limit is kept.
          nxt_tmr_st  = TMR_IDLE; // [R22]
          nxt_cnt     = '0;
          nxt_out     = 1'b1;
          nxt_int_en  = 1'b0;
          nxt_oneshot = 1'b0;
          nxt_ext_sel = 1'b0;
          nxt_route   = 1'b0;
          tmr_rst_cmd = 1'b1;
        end
        default: begin
          nxt_cnt = nxt_cnt;
        end
      endcase
    end
  end

  // Sticky device-wide flags; a new event beats a clear.
  wire nxt_tmr_pend = (tmr_evt & int_en_ff) |
                      (tmr_pend_ff & ~tmr_rd & ~tmr_rst_cmd); // [R14] [R24]
  wire nxt_wake     = wake_evt_i | (wake_ff & ~stat_rd); // [R9]
  wire nxt_pin      = pin_irq_evt_i | (pin_ff & ~pin_level_rd_i); // [R15]
  wire tmr_visible  = tmr_pend_ff & int_en_ff;

  // Channel 0 code carries the global sources below its own.
  wire [CODE_W-1:0] code0 = (code[0] != CODE_NONE) ? code[0] :
                            pin_ff                 ? CODE_PIN :  // [R7] [R8]
                            tmr_visible            ? CODE_TMR :  // [R7] [R8]
                                                     CODE_NONE; // [R5]

  // Status word: requests low, both codes in byte one.
  logic [DATA_W-1:0] status_w;
  always_comb begin
    status_w = STATUS_RST;
    status_w[REQ_LSB +: CH_N]     = req; // [R1] [R2]
    status_w[CODE0_LSB +: CODE_W] = code0; // [R3]
    status_w[CODE1_LSB +: CODE_W] = code[1]; // [R3] [R8]
  end

  // Timer word read shows the limit, never the count.
  logic [DATA_W-1:0] timer_w;
  always_comb begin
    timer_w = '0;
    timer_w[RDB_LSB +: 8]    = tmr_visible ? TMR_RD_PEND : TMR_RD_NONE; // [R23]
    timer_w[LIM_LO_LSB +: 8] = limit_ff[7:0]; // [R21]
    timer_w[LIM_HI_LSB +: 8] = limit_ff[15:8]; // [R21]
  end

  // Read data for the cycle after the strobe; unmapped reads give zero.
  wire [DATA_W-1:0] nxt_rdata = stat_rd ? status_w : // [R4]
                                tmr_rd  ? timer_w  : '0;

  // Timer registers.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_st_ff  <= TMR_IDLE;
      cnt_ff     <= '0;
      limit_ff   <= LIMIT_RST; // [R22]
      out_ff     <= 1'b1;
      int_en_ff  <= 1'b0;
      oneshot_ff <= 1'b0;
      ext_sel_ff <= 1'b0;
      route_ff   <= 1'b0;
    end else begin
      tmr_st_ff  <= nxt_tmr_st;
      cnt_ff     <= nxt_cnt;
      limit_ff   <= nxt_limit;
      out_ff     <= nxt_out;
      int_en_ff  <= nxt_int_en;
      oneshot_ff <= nxt_oneshot;
      ext_sel_ff <= nxt_ext_sel;
      route_ff   <= nxt_route;
    end
  end

  // Interrupt flags and read data.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmr_pend_ff <= 1'b0; // [R16]
      wake_ff     <= 1'b0; // [R16]
      pin_ff      <= 1'b0; // [R16]
      ext_prev_ff <= 1'b0;
      rdata_ff    <= '0;
    end else begin
      tmr_pend_ff <= nxt_tmr_pend;
      wake_ff     <= nxt_wake;
      pin_ff      <= nxt_pin;
      ext_prev_ff <= ext_sync;
      rdata_ff    <= nxt_rdata;
    end
  end

  // Outputs come straight from flip-flops.
  assign rdata_o    = rdata_ff;
  assign mpin0_o    = out_ff; // [R19]
  assign mpin0_oe_o = route_ff; // [R19]

endmodule
`default_nettype wire

// *** dv/irq_status_monitor.sv ***
/*
  Concurrent checks on the ports of the interrupt status and timer block.
  Assumes one clock domain with an asynchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_status_monitor
  import irq_timer_pkg::*;
#(
  parameter int CH_N = 2
) (
  // Clock and reset.
  input wire logic                                 sys_clk_i,
  input wire logic                                 rst_i,
  // Register port.
  input wire logic [irq_timer_pkg::ADDR_W-1:0]     addr_i,
  input wire logic [irq_timer_pkg::DATA_W-1:0]     wdata_i,
  input wire logic                                 wr_i,
  input wire logic                                 rd_i,
  input wire logic [irq_timer_pkg::DATA_W-1:0]     rdata_o,
  // Channel and device-wide sources.
  input wire irq_timer_pkg::chan_evt_s [CH_N-1:0]  chan_evt_i,
  input wire irq_timer_pkg::chan_rd_s  [CH_N-1:0]  chan_rd_i,
  input wire logic                                 wake_evt_i,
  input wire logic                                 pin_irq_evt_i,
  input wire logic                                 pin_level_rd_i,
  input wire logic                                 external_count_clock_i,
  // Pin 0 drive.
  input wire logic                                 mpin0_o,
  input wire logic                                 mpin0_oe_o
);
  import irq_timer_pkg::*;

  // Command field of the write data, decoded once.
  logic [CMD_W-1:0] cmd_w;
  assign cmd_w = wdata_i[CMD_W-1:0];

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Steps of the register port and channel traffic.
  sequence s_stat_rd; rd_i && addr_i == STATUS_OFS; endsequence
  sequence s_tmr_rd; rd_i && addr_i == TIMER_OFS; endsequence
  sequence s_ch0_evt; |chan_evt_i[0]; endsequence
  sequence s_stop_wr; wr_i && addr_i == TIMER_OFS && cmd_w == CMD_STOP; endsequence

  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data not zero outside a read answer");
  a_status_resv: assert property (
    s_stat_rd |=> rdata_o[7:2] == '0 && rdata_o[31:14] == '0)
    else $error("reserved status bits not zero");
  a_code_five: assert property (
    s_stat_rd |=> rdata_o[10:8] != 3'h5 && rdata_o[13:11] != 3'h5)
    else $error("reserved source code reported");
  a_ch1_local: assert property (s_stat_rd |=> rdata_o[13:11] < CODE_PIN)
    else $error("global source shown in channel 1 code");
  a_req_code: assert property (s_stat_rd |=>
    (rdata_o[0] == (rdata_o[10:8] inside {[3'h1:3'h4]})) &&
    (rdata_o[1] == (rdata_o[13:11] != 3'h0)))
    else $error("request bit disagrees with source code");
  a_tmr_format: assert property (s_tmr_rd |=> rdata_o[15:1] == '0)
    else $error("timer command byte not 00 or 01");
  a_evt_req: assert property (
    s_ch0_evt ##1 !(|chan_rd_i[0]) ##1 s_stat_rd |=> rdata_o[0])
    else $error("channel 0 event not seen as request");
  a_route_oe: assert property ($rose(mpin0_oe_o) |->
    $past(wr_i) && $past(addr_i) == TIMER_OFS && $past(cmd_w) == CMD_ROUTE)
    else $error("pin 0 enable rose without route command");
  a_stop_high: assert property (s_stop_wr |=> mpin0_o)
    else $error("timer output not high after stop");
endmodule

bind global_interrupt_and_timer_status irq_status_monitor #(.CH_N(CH_N)) u_irq_mon (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_evt_i(chan_evt_i),
  .chan_rd_i(chan_rd_i), .wake_evt_i(wake_evt_i), .pin_irq_evt_i(pin_irq_evt_i),
  .pin_level_rd_i(pin_level_rd_i), .external_count_clock_i(external_count_clock_i),
  .mpin0_o(mpin0_o), .mpin0_oe_o(mpin0_oe_o));
`default_nettype wire

// *** dv/global_interrupt_and_timer_status_tb.sv ***
/*
  Self-checking bench for the interrupt status and timer block.
  Drives every port itself; the checker is bound in from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module global_interrupt_and_timer_status_tb;
  import irq_timer_pkg::*;

  logic              clk      = 1'b0;
  logic              rst      = 1'b1;
  logic [ADDR_W-1:0] addr     = '0;
  logic [DATA_W-1:0] wdata    = '0;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic [DATA_W-1:0] rdata;
  chan_evt_s [1:0]   evt      = '0;
  chan_rd_s [1:0]    crd      = '0;
  logic              wake     = 1'b0;
  logic              pin_evt  = 1'b0;
  logic              pin_rd   = 1'b0;
  logic              ext_clk  = 1'b0;
  logic              mpin;
  logic              mpin_oe;
  logic [31:0]       rv;
  int                lows;
  int                n_errors = 0;
  int                compares = 0;

  // A 40 MHz clock.
  always #12.5 clk = ~clk;

  global_interrupt_and_timer_status #(.CH_N(2)) uut (
    .sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .chan_evt_i(evt), .chan_rd_i(crd),
    .wake_evt_i(wake), .pin_irq_evt_i(pin_evt), .pin_level_rd_i(pin_rd),
    .external_count_clock_i(ext_clk), .mpin0_o(mpin), .mpin0_oe_o(mpin_oe));

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Compares a 32-bit result with its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register port cycles; read data is taken in the cycle after the strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // One-cycle pulses on channel events, channel reads and global sources.
  task automatic pulse_evt(input int ch, input logic [5:0] v);
    @(posedge clk);
    evt[ch] <= v;
    @(posedge clk);
    evt[ch] <= '0;
  endtask
  task automatic pulse_rd(input int ch, input logic [3:0] v);
    @(posedge clk);
    crd[ch] <= v;
    @(posedge clk);
    crd[ch] <= '0;
  endtask
  task automatic pulse_g(input logic [2:0] m);
    @(posedge clk);
    {wake, pin_evt, pin_rd} <= m;
    @(posedge clk);
    {wake, pin_evt, pin_rd} <= 3'h0;
  endtask

  // Counts low cycles of the timer output, toggling the count pin if asked.
  task automatic count_lows(input int n, input logic tog, output int cnt);
    cnt = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (tog && i % 2 == 0) ext_clk <= ~ext_clk;
      #1;
      if (mpin !== 1'b1) cnt++;
    end
  endtask

  // Reset values, an unmapped read and an ignored status write.
  task automatic t_reset();
    rd_reg(STATUS_OFS, rv);
    chk(rv, STATUS_RST);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0);
    wr_reg(STATUS_OFS, 32'hffff_ffff);
    rd_reg(8'h88, rv);
    chk(rv, 32'h0);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h0);
  endtask

  // Every source of both channels, a wrong clear, then the right clear.
  task automatic t_codes();
    logic [2:0] code [6] = '{3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h1};
    int         clr [6]  = '{1, 0, 1, 3, 2, 3};
    logic [31:0] e;
    for (int ch = 0; ch < 2; ch++) begin
      for (int b = 0; b < 6; b++) begin
        e = (32'h1 << ch) | (32'(code[b]) << (CODE0_LSB + CODE_W * ch));
        pulse_evt(ch, 6'h1 << b);
        pulse_rd(ch, 4'h1 << ((clr[b] + 1) % 4));
        rd_reg(STATUS_OFS, rv);
        chk(rv, e);
        pulse_rd(ch, 4'h1 << clr[b]);
        rd_reg(STATUS_OFS, rv);
        chk(rv, 32'h0);
      end
    end
  endtask

  // All channel 1 sources at once, cleared one reader at a time.
  task automatic t_prio();
    logic [3:0] clr [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [2:0] exp [5] = '{3'h1, 3'h1, 3'h3, 3'h4, 3'h0};
    pulse_evt(1, 6'h3f);
    for (int i = 0; i < 5; i++) begin
      rd_reg(STATUS_OFS, rv);
      chk(rv, (32'(exp[i]) << CODE1_LSB) | {30'h0, exp[i] != 3'h0, 1'b0});
      if (i < 4) pulse_rd(1, clr[i]);
    end
  endtask

  // Wake-up leaves the status word zero; the pin source shows only in the channel 0 code.
  task automatic t_global();
    pulse_g(3'h4);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h0);
    pulse_g(3'h2);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h600);
    pulse_evt(0, 6'h20);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h101);
    pulse_rd(0, 4'h8);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h600);
    pulse_g(3'h1);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h0);
  endtask

  // One-shot timeout with a limit of five ticks.
  task automatic t_oneshot();
    wr_reg(TIMER_OFS, 32'h1234_0000);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h1234_0000);
    wr_reg(TIMER_OFS, 32'h0005_0000);
    wr_reg(TIMER_OFS, {28'h0, CMD_INT_EN});
    wr_reg(TIMER_OFS, {28'h0, CMD_ONESHOT});
    wr_reg(TIMER_OFS, {28'h0, CMD_START});
    repeat (3) @(posedge clk);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0000);
    rd_reg(STATUS_OFS, rv);
    chk(rv, 32'h700);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0001);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0000);
    chk({31'h0, mpin}, 32'h0);
    wr_reg(TIMER_OFS, {28'h0, CMD_STOP});
    #1;
    chk({31'h0, mpin}, 32'h1);
  endtask

  // Periodic mode routed to pin 0, internal then external count clock.
  task automatic t_retrig();
    wr_reg(TIMER_OFS, {28'h0, CMD_ROUTE});
    #1;
    chk({31'h0, mpin_oe}, 32'h1);
    wr_reg(TIMER_OFS, {28'h0, CMD_RETRIG});
    wr_reg(TIMER_OFS, {28'h0, CMD_START});
    count_lows(8, 1'b0, lows);
    count_lows(10, 1'b0, lows);
    chk(lows, 32'd6);
    wr_reg(TIMER_OFS, 32'h00ff_0000);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0001);
    wr_reg(TIMER_OFS, {28'h0, CMD_STOP});
    wr_reg(TIMER_OFS, {28'h0, CMD_CLK_EXT});
    wr_reg(TIMER_OFS, {28'h0, CMD_START});
    count_lows(20, 1'b0, lows);
    chk(lows, 32'd0);
    count_lows(8, 1'b1, lows);
    count_lows(80, 1'b1, lows);
    chk(lows, 32'd48);
    wr_reg(TIMER_OFS, {28'h0, CMD_RESET});
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0000);
    chk({30'h0, mpin_oe, mpin}, 32'h1);
    wr_reg(TIMER_OFS, {28'h0, CMD_ROUTE});
    wr_reg(TIMER_OFS, {28'h0, CMD_DEROUTE});
    wr_reg(TIMER_OFS, {28'h0, CMD_CLK_EXT});
    wr_reg(TIMER_OFS, {28'h0, CMD_CLK_INT});
    wr_reg(TIMER_OFS, {28'h0, CMD_INT_EN});
    wr_reg(TIMER_OFS, {28'h0, CMD_INT_DIS});
    wr_reg(TIMER_OFS, {28'h0, CMD_START});
    count_lows(10, 1'b0, lows);
    chk(lows, 32'd6);
    chk({31'h0, mpin_oe}, 32'h0);
    rd_reg(TIMER_OFS, rv);
    chk(rv, 32'h0005_0000);
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // Reset for twelve cycles, then the scenarios.
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_codes();
    t_prio();
    t_global();
    t_oneshot();
    t_retrig();
    conclude();
  end
endmodule
`default_nettype wire
